/* File: src/brp_pointer.sv */
// Behaviour
// [RULE1] Pointer upper nibble selects a 16-byte working group among 256 bytes.
// [RULE2] Pointer lower nibble selects the expanded bank seen at working addresses.
// [RULE3] Only banks 0, F and D exist; other banks have no storage.
// [RULE4] Lower nibble zero leaves the lowest addresses on the normal file.
// [RULE5] Lower nibble 1h to Fh swaps the lowest 16 addresses to that bank.
// [RULE6] Pointer 00h maps working registers 0 to 3 onto port registers 0 to 3.
// [RULE7] Pointer 0Dh maps working registers 0 to 3 onto timer control registers.
// [RULE8] Addresses above the lowest 16 always reach the normal file.
`timescale 1ns/100ps
`include "brp_defs.svh"

module brp_pointer (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Core access
    input brp_pkg::brp_req_s req_i,
    // Translated access, write data, timer control select and pointer
    output brp_pkg::brp_map_s map_o,
    output logic map_valid_o,
    output logic map_write_o,
    output logic [7:0] map_wdata_o,
    output logic [3:0] timer_ctrl_sel_o,
    output logic [7:0] register_group_pointer_o
);
    import brp_pkg::*;

    // ----------------------------------------
    // Translation
    // ----------------------------------------
    function automatic brp_map_s brp_translate(input logic [7:0] addr, input logic [3:0] bank);
        brp_map_s m;
        m.index = addr;
        m.target = BRP_TGT_NORMAL;
        if (addr[7:4] == `BRP_LOW_GROUP && bank != `BRP_BANK_NORMAL) begin
            if (bank == `BRP_BANK_F) begin
                m.target = BRP_TGT_BANK_F;
            end else if (bank == `BRP_BANK_D) begin
                m.target = BRP_TGT_BANK_D;
            end else begin
                m.target = BRP_TGT_NONE;
            end
        end
        return m;
    endfunction

    logic [7:0] register_group_pointer_r;
    brp_map_s map_r;
    logic map_valid_r;
    logic map_write_r;
    logic [7:0] map_wdata_r;
    logic [3:0] timer_sel_r;

    wire logic [3:0] group_w = register_group_pointer_r[`BRP_GROUP_HI:`BRP_GROUP_LO];
    wire logic [3:0] bank_w = register_group_pointer_r[`BRP_BANK_HI:`BRP_BANK_LO];
    // Working addresses take the group from the pointer
    wire logic [7:0] eff_addr_w = req_i.work_sel ? {group_w, req_i.addr[3:0]} : req_i.addr; // [RULE1]
    // Bank swap only below 16, elsewhere the normal file
    wire brp_map_s map_nxt = brp_translate(eff_addr_w, bank_w); // [RULE2] [RULE3] [RULE4] [RULE5] [RULE8]
    wire logic ptr_wr_w = req_i.valid && req_i.write && eff_addr_w == `BRP_PTR_ADDR;
    wire logic timer_hit_w = req_i.valid && map_nxt.target == BRP_TGT_BANK_D
                             && eff_addr_w[3:0] <= `BRP_TIMER_LAST;
    wire logic [3:0] timer_sel_nxt = timer_hit_w ? 4'(4'h1 << eff_addr_w[1:0]) : 4'h0; // [RULE7]

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            register_group_pointer_r <= `BRP_PTR_RESET;
        end else if (ptr_wr_w) begin
            register_group_pointer_r <= req_i.wdata;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            map_r <= '0;
            map_valid_r <= 1'b0;
            map_write_r <= 1'b0;
            map_wdata_r <= 8'h00;
            timer_sel_r <= 4'h0;
        end else begin
            map_r <= map_nxt; // [RULE6]
            map_valid_r <= req_i.valid;
            map_write_r <= req_i.valid && req_i.write;
            map_wdata_r <= req_i.wdata;
            timer_sel_r <= timer_sel_nxt;
        end
    end

    assign map_o = map_r;
    assign map_valid_o = map_valid_r;
    assign map_write_o = map_write_r;
    assign map_wdata_o = map_wdata_r;
    assign timer_ctrl_sel_o = timer_sel_r;
    assign register_group_pointer_o = register_group_pointer_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_work_req;
        req_i.valid && req_i.work_sel;
    endsequence

    sequence s_low_quad;
        req_i.addr[3:2] == 2'h0;
    endsequence

    chk_group_select: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE1]
        s_work_req |=> map_r.index == {$past(group_w), $past(req_i.addr[3:0])})
        else $error("working address not formed from pointer group");

    chk_bank_follow: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE2]
        req_i.valid && eff_addr_w[7:4] == 4'h0 && bank_w == 4'hD |=> map_r.target == BRP_TGT_BANK_D)
        else $error("bank D not selected by pointer");

    chk_unbacked_bank: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE3]
        req_i.valid && eff_addr_w[7:4] == 4'h0 && bank_w != 4'h0 && bank_w != 4'hD && bank_w != 4'hF
        |=> map_r.target == BRP_TGT_NONE)
        else $error("unimplemented bank got storage");

    chk_bank_zero: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE4]
        req_i.valid && bank_w == 4'h0 |=> map_r.target == BRP_TGT_NORMAL)
        else $error("bank 0 not normal file");

    chk_bank_swap: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE5]
        req_i.valid && eff_addr_w[7:4] == 4'h0 && bank_w == 4'hF |=> map_r.target == BRP_TGT_BANK_F)
        else $error("bank F swap missing");

    chk_port_map: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE6]
        (s_work_req and s_low_quad and (register_group_pointer_r == 8'h00))
        |=> map_r.target == BRP_TGT_NORMAL && map_r.index == {6'h00, $past(req_i.addr[1:0])})
        else $error("port registers not reached");

    chk_timer_map: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE7]
        (s_work_req and s_low_quad and (register_group_pointer_r == 8'h0D))
        |=> map_r.target == BRP_TGT_BANK_D && timer_ctrl_sel_o == 4'(4'h1 << $past(req_i.addr[1:0])))
        else $error("timer control register not selected");

    chk_high_normal: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE8]
        req_i.valid && eff_addr_w[7:4] != 4'h0 |=> map_r.target == BRP_TGT_NORMAL && timer_ctrl_sel_o == 4'h0)
        else $error("high address was banked");

    chk_ptr_write: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE1]
        ptr_wr_w |=> register_group_pointer_o == $past(req_i.wdata))
        else $error("pointer write lost");

    // ----------------------------------------
    // Checks on the handed-over access and the pointer
    // ----------------------------------------
    sequence s_idle_req;
        !req_i.valid;
    endsequence

    sequence s_write_req;
        req_i.valid && req_i.write;
    endsequence

    sequence s_low_req;
        req_i.valid && eff_addr_w[7:4] == `BRP_LOW_GROUP;
    endsequence

    sequence s_high_req;
        req_i.valid && eff_addr_w[7:4] != `BRP_LOW_GROUP;
    endsequence

    sequence s_timer_slot;
        eff_addr_w[3:0] <= `BRP_TIMER_LAST;
    endsequence

    sequence s_ptr_by_work;
        req_i.write && group_w == 4'hF && req_i.addr[3:0] == 4'hD;
    endsequence

    chk_valid_follow: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE2]
        req_i.valid |=> map_valid_o && map_r.index == $past(eff_addr_w))
        else $error("access not handed over");

    chk_idle_quiet: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE7]
        s_idle_req |=> !map_valid_o && !map_write_o && timer_ctrl_sel_o == 4'h0)
        else $error("idle cycle produced an access");

    chk_write_follow: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE2]
        s_write_req |=> map_write_o && map_wdata_o == $past(req_i.wdata))
        else $error("write data not handed over");

    chk_timer_hit: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE7]
        (s_low_req and s_timer_slot and (bank_w == `BRP_BANK_D))
        |=> timer_ctrl_sel_o == 4'(4'h1 << $past(eff_addr_w[1:0])))
        else $error("timer control register not reached");

    chk_timer_only_d: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE7]
        timer_ctrl_sel_o != 4'h0
        |-> map_valid_o && map_r.target == BRP_TGT_BANK_D && map_r.index[3:0] <= `BRP_TIMER_LAST)
        else $error("timer control selected outside bank D");

    chk_bank_d_index: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE3]
        (s_low_req and (bank_w == `BRP_BANK_D))
        |=> map_r.target == BRP_TGT_BANK_D && map_r.index == $past(eff_addr_w))
        else $error("bank D access lost its register number");

    chk_bank_f_work: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE5]
        (s_work_req and (group_w == `BRP_LOW_GROUP) and (bank_w == `BRP_BANK_F))
        |=> map_r.target == BRP_TGT_BANK_F && map_r.index[7:4] == `BRP_LOW_GROUP)
        else $error("working register not swapped to bank F");

    chk_low_index: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE5]
        (s_low_req and (bank_w != `BRP_BANK_NORMAL))
        |=> map_r.target != BRP_TGT_NORMAL && map_r.index[3:0] == $past(req_i.addr[3:0]))
        else $error("banked access lost its register number");

    chk_high_index: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE8]
        s_high_req |=> map_r.index == $past(eff_addr_w) && map_r.index[7:4] != `BRP_LOW_GROUP)
        else $error("high address changed on the way");

    chk_work_ptr: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE1]
        (s_work_req and s_ptr_by_work) |=> register_group_pointer_o == $past(req_i.wdata))
        else $error("pointer not written through working register");

    chk_ptr_hold: assert property (@(posedge mclk_i) disable iff (reset_i) // [RULE1]
        !ptr_wr_w |=> $stable(register_group_pointer_o))
        else $error("pointer changed without a write");

    // ----------------------------------------
    // Reset
    // ----------------------------------------
    chk_reset_clear: assert property (@(posedge mclk_i) reset_i // [RULE4]
        |=> register_group_pointer_o == `BRP_PTR_RESET && map_o == '0 && !map_valid_o && !map_write_o
        && map_wdata_o == 8'h00 && timer_ctrl_sel_o == 4'h0)
        else $error("reset left state behind");

endmodule

/* File: src/brp_defs.svh */
`ifndef BRP_DEFS_SVH
`define BRP_DEFS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define BRP_PTR_ADDR 8'hFD
`define BRP_PTR_RESET 8'h00

// ----------------------------------------
// Field positions of the pointer
// ----------------------------------------
`define BRP_GROUP_HI 7
`define BRP_GROUP_LO 4
`define BRP_BANK_HI 3
`define BRP_BANK_LO 0

// ----------------------------------------
// Bank codes, low group and last timer slot
// ----------------------------------------
`define BRP_BANK_NORMAL 4'h0
`define BRP_BANK_F 4'hF
`define BRP_BANK_D 4'hD
`define BRP_LOW_GROUP 4'h0
`define BRP_TIMER_LAST 4'h3

`endif

/* File: src/brp_pkg.sv */
package brp_pkg;

    // ----------------------------------------
    // Target kinds
    // ----------------------------------------
    typedef enum logic [1:0] {
        BRP_TGT_NORMAL,
        BRP_TGT_BANK_F,
        BRP_TGT_BANK_D,
        BRP_TGT_NONE
    } brp_target_e;

    // ----------------------------------------
    // Translated access
    // ----------------------------------------
    typedef struct packed {
        brp_target_e target;
        logic [7:0] index;
    } brp_map_s;

    // ----------------------------------------
    // Access request from the core
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic work_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } brp_req_s;

endpackage

/* File: verification/brp_core_model.sv */
`timescale 1ns/100ps
module brp_core_model (
    // Clock
    input wire logic mclk_i,
    // Request
    output brp_pkg::brp_req_s req_o
);
    import brp_pkg::*;
    initial begin
        req_o = '0;
    end
    // One access, held across one rising edge, then scrambled idle
    task automatic access(input logic wr, input logic ws, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        req_o = '{valid: 1'b1, write: wr, work_sel: ws, addr: a, wdata: d};
        @(negedge mclk_i);
        req_o = '{valid: 1'b0, write: ~wr, work_sel: ~ws, addr: ~a, wdata: ~d};
    endtask
endmodule

/* File: verification/banked_register_pointer_tb.sv */
`timescale 1ns/100ps
module banked_register_pointer_tb;
    import brp_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    brp_req_s req;
    brp_map_s map, em;
    logic mv, mw;
    logic [7:0] wd, ptr, eptr;
    logic [3:0] ts;
    int fails = 0;
    int checks = 0;
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    brp_core_model core (.mclk_i(mclk_i), .req_o(req));
    brp_pointer dut (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req), .map_o(map), .map_valid_o(mv),
        .map_write_o(mw), .map_wdata_o(wd), .timer_ctrl_sel_o(ts), .register_group_pointer_o(ptr));
    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Access through the core and judge the translation
    task automatic go(input logic wr, input logic ws, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] e;
        e = ws ? {eptr[7:4], a[3:0]} : a;
        em.index = e;
        em.target = (e[7:4] != 4'h0 || eptr[3:0] == 4'h0) ? BRP_TGT_NORMAL : eptr[3:0] == 4'hF ?
            BRP_TGT_BANK_F : eptr[3:0] == 4'hD ? BRP_TGT_BANK_D : BRP_TGT_NONE;
        core.access(wr, ws, a, d);
        check("map", map, em);
        check("valid", 10'(mv), 10'h001);
        check("write", 10'(mw), 10'(wr));
        check("wdata", 10'(wd), 10'(d));
        check("tsel", 10'(ts), (em.target == BRP_TGT_BANK_D && e[3:0] <= 4'h3) ? 10'h001 << e[1:0] : 10'h000);
        if (wr && e == 8'hFD) begin
            eptr = d;
        end
        check("pointer", 10'(ptr), 10'(eptr));
        // Idle cycle after the access hands nothing over
        @(negedge mclk_i);
        check("idle valid", 10'(mv), 10'h000);
        check("idle write", 10'(mw), 10'h000);
        check("idle tsel", 10'(ts), 10'h000);
        check("idle pointer", 10'(ptr), 10'(eptr));
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_timer();
        go(1'b1, 1'b0, 8'hFD, 8'h0D);
        for (int i = 0; i < 5; i++) begin
            go(1'b0, 1'b1, 8'(i), 8'h00);
        end
    endtask
    task automatic t_banks();
        for (int b = 0; b < 16; b++) begin
            go(1'b1, 1'b0, 8'hFD, 8'(b));
            go(1'b0, 1'b0, 8'h05, 8'h00);
            go(1'b0, 1'b1, 8'h0E, 8'h00);
            go(1'b0, 1'b0, 8'h15, 8'h00);
        end
    endtask
    task automatic t_group();
        go(1'b1, 1'b0, 8'hFD, 8'hF0);
        go(1'b0, 1'b1, 8'h03, 8'h00);
        go(1'b1, 1'b1, 8'h0D, 8'h20);
        go(1'b0, 1'b1, 8'h02, 8'h00);
        go(1'b1, 1'b0, 8'hFD, 8'h00);
        for (int i = 0; i < 4; i++) begin
            go(1'b0, 1'b1, 8'(i), 8'h00);
        end
    endtask
    task automatic t_reset();
        go(1'b1, 1'b0, 8'hFD, 8'h3D);
        go(1'b0, 1'b1, 8'h02, 8'h00);
        reset_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        check("reset pointer", 10'(ptr), 10'h000);
        check("reset map", map, 10'h000);
        check("reset valid", 10'(mv), 10'h000);
        check("reset write", 10'(mw), 10'h000);
        check("reset wdata", 10'(wd), 10'h000);
        check("reset tsel", 10'(ts), 10'h000);
        reset_i = 1'b0;
        eptr = 8'h00;
        go(1'b0, 1'b1, 8'h02, 8'h00);
    endtask
    initial begin
        eptr = 8'h00;
        repeat (10) @(posedge mclk_i);
        @(negedge mclk_i);
        reset_i = 1'b0;
        check("reset pointer", 10'(ptr), 10'h000);
        t_timer();
        t_banks();
        t_group();
        t_reset();
        end_sim();
    end
    initial begin
        #20000;
        fails++;
        end_sim();
    end
endmodule
